// File: core/eeprom_map.svh
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH
// instruction opcodes: read and write as upper seven bits (bit 0 may carry address bit 8), enable and disable as full eight bits
`define OP_READ_HI 7'h54
`define OP_WRITE_HI 7'h52
`define OP_ENABLE 8'hA3
`define OP_DISABLE 8'hA0
// bit counts of one instruction
`define OPCODE_BITS 8
`define HEADER_BITS 16
`define WRITE_LAST_BIT 32
`define CMD_LAST_BIT 17
// self-timed programming time in ns
`define PROG_TIME_NS 10000000
`define CLK_PERIOD_NS 25
`endif

// File: core/eeprom_pkg.sv
package eeprom_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_STATUS,
        ST_SHIFT,
        ST_READ,
        ST_IGNORE,
        ST_BUSY
    } eng_state_t;
endpackage : eeprom_pkg

// File: core/serial_eeprom_instruction_engine.sv
`include "eeprom_map.svh"
// Contract
// - 32nd rising edge starts programming busy
// - reset high aborts programming, returns ready
// - reset high blocks any write
// - programming completes regardless of chip select
// - only read drives data, else status
// - read output starts on 17th falling edge
// - read word shifted out from D15 down
// - continued clocking advances address per word
// - read address wraps from top to zero
// - write-enable latch disabled at power-up
// - enable latch holds until disable command
// - reads ignore the write-enable latch
// - clocks beyond 16th ignored for enable/disable
// - eight-bit opcode, address, sixteen data bits
// - sample on rising, change on falling
// - status output when selected with clock low
// - chip select rising abandons the instruction
module serial_eeprom_instruction_engine #(
    parameter int ADDR_W = 9,
    parameter int PROG_CYCLES = `PROG_TIME_NS / `CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic serial_clock_n,
    input wire logic serial_data_in,
    input wire logic write_reset,
    output logic serial_data_out,
    output logic serial_data_oe,
    output logic busy
);
    import eeprom_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;

    // ************************************************
    // pin synchronisers
    // ************************************************
    logic [1:0] cs_s_r, sk_s_r, di_s_r, rs_s_r;
    logic sk_d_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_s_r <= 2'h3;
            sk_s_r <= 2'h3;
            di_s_r <= 2'h0;
            rs_s_r <= 2'h0;
            sk_d_r <= 1'b1;
        end else begin
            cs_s_r <= {cs_s_r[0], chip_select_n};
            sk_s_r <= {sk_s_r[0], serial_clock_n};
            di_s_r <= {di_s_r[0], serial_data_in};
            rs_s_r <= {rs_s_r[0], write_reset};
            sk_d_r <= sk_s_r[1];
        end
    end
    wire cs_n = cs_s_r[1];
    wire sk = sk_s_r[1];
    wire di = di_s_r[1];
    wire wr_reset = rs_s_r[1];
    wire sk_rise = sk & ~sk_d_r;
    wire sk_fall = ~sk & sk_d_r;

    // ************************************************
    // storage array
    // ************************************************
    logic [15:0] mem [DEPTH];

    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
        next_addr = a + ADDR_W'(1); // natural overflow wraps top to zero
    endfunction : next_addr

    // ************************************************
    // engine state
    // ************************************************
    eng_state_t state_r, state_nxt;
    logic cs_d_r, cs_d_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [15:0] shift_r, shift_nxt;
    logic [7:0] op_r, op_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [3:0] rbit_r, rbit_nxt;
    logic wen_r, wen_nxt;
    logic [31:0] prog_r, prog_nxt;
    logic do_r, do_nxt, oe_r, oe_nxt;
    logic mem_we;
    logic [15:0] mem_wd;

    wire cs_fall = ~cs_n & cs_d_r;
    wire is_read = op_r[7:1] == `OP_READ_HI;
    wire is_write = op_r[7:1] == `OP_WRITE_HI;

    // next-state decode for the instruction engine
    always_comb begin
        state_nxt = state_r;
        cs_d_nxt = cs_n;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        op_nxt = op_r;
        addr_nxt = addr_r;
        rbit_nxt = rbit_r;
        wen_nxt = wen_r;
        prog_nxt = prog_r;
        do_nxt = do_r;
        oe_nxt = oe_r;
        mem_we = 1'b0;
        mem_wd = shift_r;
        unique case (state_r)
            ST_IDLE: begin
                oe_nxt = 1'b0;
                if (cs_fall) begin
                    cnt_nxt = '0;
                    if (sk) begin
                        state_nxt = ST_SHIFT;
                    end else begin
                        state_nxt = ST_STATUS;
                        do_nxt = 1'b1;
                        oe_nxt = 1'b1;
                    end
                end
            end
            ST_STATUS: begin
                // first opcode bit is a one; it ends status and is taken
                if (cs_n || (sk_rise && di)) begin
                    oe_nxt = 1'b0;
                    state_nxt = cs_n ? ST_IDLE : ST_SHIFT;
                    shift_nxt = {shift_r[14:0], di};
                    cnt_nxt = 6'd1;
                end
            end
            ST_SHIFT: begin
                if (cs_n) begin
                    state_nxt = ST_IDLE;
                end else if (sk_rise) begin
                    shift_nxt = {shift_r[14:0], di};
                    cnt_nxt = cnt_r + 6'd1;
                    if (cnt_r + 6'd1 == 6'(`OPCODE_BITS)) begin
                        op_nxt = {shift_r[6:0], di};
                    end
                    if (cnt_r + 6'd1 == 6'(`HEADER_BITS)) begin
                        addr_nxt = ADDR_W'({op_r[0], shift_r[6:0], di});
                        if (ADDR_W < 9 || !(is_read || is_write)) begin
                            // smallest density closes the field with a zero bit
                            addr_nxt = ADDR_W'({shift_r[6:0], di} >> ((ADDR_W < 8) ? 1 : 0));
                        end
                        if (is_read) begin
                            state_nxt = ST_READ;
                            rbit_nxt = 4'hF;
                        end else if (!is_write) begin
                            if (op_r == `OP_ENABLE) begin
                                wen_nxt = 1'b1;
                            end else if (op_r == `OP_DISABLE) begin
                                wen_nxt = 1'b0;
                            end
                            state_nxt = ST_IGNORE;
                        end
                    end
                    if (cnt_r + 6'd1 == 6'(`WRITE_LAST_BIT)) begin
                        // latch and reset both gate the write
                        if (wen_r && !wr_reset) begin
                            state_nxt = ST_BUSY;
                            prog_nxt = '0;
                        end else begin
                            state_nxt = ST_IGNORE;
                        end
                    end
                end
            end
            ST_READ: begin
                if (cs_n) begin
                    state_nxt = ST_IDLE;
                    oe_nxt = 1'b0;
                end else if (sk_fall) begin
                    oe_nxt = 1'b1;
                    do_nxt = mem[addr_r][rbit_r];
                    rbit_nxt = rbit_r - 4'd1;
                    if (rbit_r == 4'd0) begin
                        addr_nxt = next_addr(addr_r);
                    end
                end
            end
            ST_IGNORE: begin
                if (cs_n) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_BUSY: begin
                // status reads low while busy if the host selects with clock low
                oe_nxt = ~cs_n & oe_r;
                if (cs_fall && !sk) begin
                    oe_nxt = 1'b1;
                end
                do_nxt = 1'b0;
                if (wr_reset) begin
                    state_nxt = ST_IDLE;
                    oe_nxt = 1'b0;
                    mem_we = 1'b1;
                    mem_wd = 16'hFFFF; // word left incomplete by the abort
                end else if (prog_r == 32'(PROG_CYCLES - 1)) begin
                    mem_we = 1'b1;
                    state_nxt = oe_r ? ST_STATUS : ST_IGNORE;
                    if (cs_n) begin
                        state_nxt = ST_IDLE;
                    end
                    do_nxt = 1'b1;
                end else begin
                    prog_nxt = prog_r + 32'd1;
                end
            end
        endcase
    end

    // registers; the latch powers up disabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cs_d_r <= 1'b1;
            cnt_r <= '0;
            shift_r <= '0;
            op_r <= '0;
            addr_r <= '0;
            rbit_r <= '0;
            wen_r <= 1'b0;
            prog_r <= '0;
            do_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cs_d_r <= cs_d_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            op_r <= op_nxt;
            addr_r <= addr_nxt;
            rbit_r <= rbit_nxt;
            wen_r <= wen_nxt;
            prog_r <= prog_nxt;
            do_r <= do_nxt;
            oe_r <= oe_nxt;
        end
    end

    // array write at end of programming; no reset on storage
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[addr_r] <= mem_wd;
        end
    end

    assign serial_data_out = do_r;
    assign serial_data_oe = oe_r;
    assign busy = state_r == ST_BUSY;
endmodule : serial_eeprom_instruction_engine

// File: verification/eeprom_sva.sv
module eeprom_sva #(
    parameter int PROG_CYCLES = 50
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic serial_clock_n,
    input wire logic write_reset,
    input wire logic serial_data_out,
    input wire logic serial_data_oe,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_r;
    int cnt_nxt;
    logic abort_r;
    logic abort_nxt;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ********
    // busy length and abort tracking
    // ********
    always_comb begin
        cnt_nxt = busy ? cnt_r + 1 : 0;
        abort_nxt = busy && (abort_r || write_reset); // aborted runs are exempt from the length check
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 0;
            abort_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            abort_r <= abort_nxt;
        end
    end
    // status request while programming
    sequence s_status_req;
        $fell(chip_select_n) && !serial_clock_n && busy;
    endsequence
    sequence s_shows_busy;
        serial_data_oe && !serial_data_out;
    endsequence
    a_abort_ends_busy: assert property (busy && write_reset |-> ##[1:5] !busy) else $error("busy kept");
    a_hw_protect: assert property ($rose(busy) |-> !write_reset) else $error("write under reset");
    a_prog_length: assert property ($fell(busy) && !abort_r |-> cnt_r inside {[PROG_CYCLES - 1:PROG_CYCLES + 1]})
        else $error("busy length off");
    a_prog_bound: assert property (busy |-> cnt_r <= PROG_CYCLES + 1) else $error("busy too long");
    a_cs_release: assert property (chip_select_n [*5] |-> !serial_data_oe) else $error("output kept");
    a_oe_start: assert property ($rose(serial_data_oe) |-> !$past(serial_clock_n, 2) && !chip_select_n)
        else $error("output start wrong");
    a_out_edge: assert property ($changed(serial_data_out) && serial_data_oe && $past(serial_data_oe) && !busy
        && !$past(busy, 3) |-> !$past(serial_clock_n)) else $error("output moved off edge");
    a_status_busy: assert property (s_status_req |-> ##[2:6] s_shows_busy) else $error("no busy status");
endmodule : eeprom_sva

bind serial_eeprom_instruction_engine eeprom_sva #(.PROG_CYCLES(PROG_CYCLES)) u_eeprom_sva (.clk, .rst,
    .chip_select_n, .serial_clock_n, .write_reset, .serial_data_out, .serial_data_oe, .busy);

// File: verification/host_port.sv
module host_port (
    input wire logic clk,
    input wire logic dout,
    input wire logic doe,
    output logic cs_n,
    output logic sk,
    output logic di
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] got;
    logic [63:0] got_oe;
    // serial clock idles high so a select starts an instruction
    initial begin
        cs_n = 1'b1;
        sk = 1'b1;
        di = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : hold
    // bits msb first; capture late in the high half, data lags a fall by ~3 clk
    task automatic xfer(input logic [63:0] bits, input int n);
        got = '0;
        got_oe = '0;
        cs_n = 1'b0;
        hold(4);
        for (int i = n - 1; i >= 0; i--) begin
            sk = 1'b0;
            di = bits[i];
            hold(4);
            sk = 1'b1;
            hold(4);
            got = {got[62:0], dout};
            got_oe = {got_oe[62:0], doe};
        end
        cs_n = 1'b1;
        di = ~di;
        hold(12);
    endtask : xfer
    task automatic status(output logic o, output logic e);
        sk = 1'b0;
        hold(4);
        cs_n = 1'b0;
        hold(6);
        o = dout;
        e = doe;
        cs_n = 1'b1;
        hold(4);
        sk = 1'b1;
        hold(8);
    endtask : status
endmodule : host_port

// File: verification/serial_eeprom_instruction_engine_test.sv
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin miscompares++; $display("wrong value %0t %h %h", $time, g, x); end end
module serial_eeprom_instruction_engine_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic write_reset = 1'b0;
    logic cs_n, sk, di, dout, doe, busy, we, o, e;
    logic [15:0] mem [512];
    int miscompares = 0;
    int checked = 0;
    always #12.5 clk = ~clk;
    serial_eeprom_instruction_engine #(.ADDR_W(9), .PROG_CYCLES(50)) u_serial_eeprom_instruction_engine (.clk, .rst,
        .chip_select_n(cs_n), .serial_clock_n(sk), .serial_data_in(di), .write_reset, .serial_data_out(dout),
        .serial_data_oe(doe), .busy);
    host_port host (.clk, .dout, .doe, .cs_n, .sk, .di);
    // ********
    // model-side tasks
    // ********
    task automatic cmd(input logic [7:0] op, input int n);
        host.xfer({op, 56'h0} >> (64 - n), n);
        if (op == 8'hA3) we = 1'b1;
        if (op == 8'hA0) we = 1'b0;
    endtask : cmd
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        host.xfer({32'h0, 7'h52, a, d}, 32);
        `CHK(busy, we && !write_reset)
        if (we && !write_reset) mem[a] = d;
        for (int i = 0; i < 90 && busy !== 1'b0; i++) host.hold(1);
        `CHK(busy, 1'b0)
    endtask : wr
    task automatic rd(input logic [8:0] a, input int w);
        host.xfer(64'({7'h54, a}) << (16 * w), 16 + 16 * w);
        `CHK(host.got_oe, (64'h1 << (16 * w)) - 1)
        for (int k = 0; k < w; k++) `CHK(host.got[16 * k +: 16], mem[(a + w - 1 - k) % 512])
    endtask : rd
    task automatic wrap_up;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #2ms;
        miscompares++;
        wrap_up();
    end
    initial begin
        void'($urandom(78));
        we = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        host.hold(4);
        wr(9'h000, 16'h1234);
        cmd(8'hA3, 24);
        for (int i = 0; i < 3; i++) wr(9'(9'h1FF + i), 16'($urandom));
        rd(9'h1FF, 3);
        // abort a write in flight, status shows busy first
        host.xfer({32'h0, 7'h52, 9'h002, 16'h0F0F}, 32);
        host.status(o, e);
        `CHK({e, o}, 2'b10)
        write_reset = 1'b1;
        host.hold(8);
        `CHK(busy, 1'b0)
        mem[2] = 16'hFFFF;
        wr(9'h003, 16'h5555);
        write_reset = 1'b0;
        wr(9'h003, 16'($urandom));
        host.status(o, e);
        `CHK({e, o}, 2'b11)
        // write cut after 24 bits must not start programming or land
        host.xfer(64'({7'h52, 9'h001, 8'hC3}), 24);
        `CHK(busy, 1'b0)
        cmd(8'hA0, 40);
        wr(9'h003, 16'hAAAA);
        rd(9'h001, 3);
        wrap_up();
    end
endmodule : serial_eeprom_instruction_engine_test
